// ---- logic/port1_pkg.sv ----
// Package with register map, field layout and reset values for port 1
package port1_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_DATA_LATCH = 16'hffd4;
    localparam logic [15:0] ADDR_DIRECTION = 16'hffe4;
    localparam logic [15:0] ADDR_PULLUP = 16'hffed;
    localparam logic [15:0] ADDR_FUNC_SEL = 16'hfffc;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN_MASK = 8'hf1;
    localparam logic [7:0] FUNC_SEL_FIXED_ONE = 8'h04;
    localparam logic [7:0] DATA_LATCH_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [7:0] FUNC_SEL_RESET = 8'h04;
    localparam logic [7:0] DIRECTION_READ = 8'hff;
    localparam int BIT_INT_THREE = 7;
    localparam int BIT_INT_TWO = 6;
    localparam int BIT_INT_ONE = 5;
    localparam int BIT_PWM = 4;
    localparam int BIT_TIMER_CLK = 0;

    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    // Alternate-function outputs into the pin mux
    typedef struct packed {
        logic pwm_out;
        logic timer_clk_out;
    } alt_out_s;

endpackage

// ---- logic/port1_pin_cell.sv ----
// One port pin: output mux, enable and pull-up control
`timescale 1ns/1ps
module port1_pin_cell (
    input wire logic func_sel,
    input wire logic alt_drive,
    input wire logic alt_value,
    input wire logic direction,
    input wire logic latch,
    input wire logic pullup_bit,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pullup_on
);

    logic gpio_drive;

    assign gpio_drive = !func_sel && direction; // RULE5 RULE2
    // Latch drives pin in GPIO output mode
    assign pin_out = func_sel ? alt_value : latch; // RULE13 RULE11
    assign pin_oe_n = !(gpio_drive || (func_sel && alt_drive)); // RULE13
    assign pullup_on = !func_sel && !direction && pullup_bit; // RULE7

endmodule

// ---- logic/port1_gpio.sv ----
// Port 1 general-purpose I/O with pull-ups and pin function select
// Function
// (RULE1) Only pins 7, 6, 5, 4 and 0 exist, each with data, direction, pull-up.
// (RULE2) A direction bit of 1 makes the pin an output, 0 an input.
// (RULE3) Reading data of an output pin returns its latch bit.
// (RULE4) Reading data of an input pin returns the sampled pin level.
// (RULE5) Direction and latch act only when the pin is in GPIO mode; the data read still picks latch or pin by direction in alternate mode.
// (RULE6) The direction register is write-only and reads as all ones.
// (RULE7) For an input pin, a pull-up bit of 1 turns the pull-up on.
// (RULE8) Bits 3 to 1 of data and pull-up registers read 0, ignore writes.
// (RULE9) Reset clears the data latch, direction and pull-up registers.
// (RULE10) Reset sets the function select register to 0x04.
// (RULE11) A function select bit of 1 hands its pin to the alternate function.
// (RULE12) Function select bit 2 reads 1 fixed, bits 3 and 1 read 0.
// (RULE13) A GPIO output pin is driven with its latch bit.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module port1_gpio (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE_N,
    output logic [7:0] PULLUP_EN,
    input wire logic PWM_OUT,
    input wire logic TIMER_CLK_OUT,
    output logic EXT_INTERRUPT_THREE_SELECT,
    output logic EXT_INTERRUPT_TWO_SELECT,
    output logic EXT_INTERRUPT_ONE_SELECT,
    output logic TIMER_TRIGGER_INPUT,
    output logic EXT_INTERRUPT_THREE_LEVEL,
    output logic EXT_INTERRUPT_TWO_LEVEL,
    output logic EXT_INTERRUPT_ONE_LEVEL,
    output logic TRIGGER_LEVEL
);

    // ----------------------------------------------------------------
    // Registers and synchroniser
    // ----------------------------------------------------------------
    port1_pkg::bus_req_s req;
    port1_pkg::alt_out_s alt;
    logic [7:0] port_data_latch;
    logic [7:0] port_direction_control;
    logic [7:0] port_pullup_enable;
    logic [7:0] port_pin_function_select;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] data_read;
    logic [7:0] next_rdata;
    logic [7:0] alt_drive;
    logic [7:0] alt_value;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign alt = '{pwm_out: PWM_OUT, timer_clk_out: TIMER_CLK_OUT};

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= PIN_IN;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            port_data_latch <= port1_pkg::DATA_LATCH_RESET; // RULE9
        end else if (req.wr && req.addr == port1_pkg::ADDR_DATA_LATCH) begin
            port_data_latch <= req.wdata & port1_pkg::PIN_MASK; // RULE8 RULE1
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            port_direction_control <= port1_pkg::DIRECTION_RESET; // RULE9
        end else if (req.wr && req.addr == port1_pkg::ADDR_DIRECTION) begin
            port_direction_control <= req.wdata & port1_pkg::PIN_MASK; // RULE2
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            port_pullup_enable <= port1_pkg::PULLUP_RESET; // RULE9
        end else if (req.wr && req.addr == port1_pkg::ADDR_PULLUP) begin
            port_pullup_enable <= req.wdata & port1_pkg::PIN_MASK; // RULE8
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            port_pin_function_select <= port1_pkg::FUNC_SEL_RESET; // RULE10
        end else if (req.wr && req.addr == port1_pkg::ADDR_FUNC_SEL) begin
            // Bit 2 held at one, bits 3 and 1 at zero
            port_pin_function_select <= (req.wdata & port1_pkg::PIN_MASK)
                | port1_pkg::FUNC_SEL_FIXED_ONE; // RULE12
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Outputs read latch, inputs read pin
    assign data_read = ((port_direction_control & port_data_latch)
        | (~port_direction_control & pin_sync))
        & port1_pkg::PIN_MASK; // RULE3 RULE4 RULE8

    always_comb begin
        next_rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                port1_pkg::ADDR_DATA_LATCH: next_rdata = data_read;
                port1_pkg::ADDR_DIRECTION:
                    next_rdata = port1_pkg::DIRECTION_READ; // RULE6
                port1_pkg::ADDR_PULLUP: next_rdata = port_pullup_enable;
                port1_pkg::ADDR_FUNC_SEL:
                    next_rdata = port_pin_function_select; // RULE12
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Pin cells
    // ----------------------------------------------------------------
    always_comb begin
        alt_drive = 8'h00;
        alt_value = 8'h00;
        alt_drive[port1_pkg::BIT_PWM] = 1'b1;
        alt_drive[port1_pkg::BIT_TIMER_CLK] = 1'b1;
        alt_value[port1_pkg::BIT_PWM] = alt.pwm_out; // RULE11
        alt_value[port1_pkg::BIT_TIMER_CLK] = alt.timer_clk_out; // RULE11
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            if (port1_pkg::PIN_MASK[i]) begin : g_used
                port1_pin_cell u_cell (
                    .func_sel(port_pin_function_select[i]),
                    .alt_drive(alt_drive[i]),
                    .alt_value(alt_value[i]),
                    .direction(port_direction_control[i]),
                    .latch(port_data_latch[i]),
                    .pullup_bit(port_pullup_enable[i]),
                    .pin_out(PIN_OUT[i]),
                    .pin_oe_n(PIN_OE_N[i]),
                    .pullup_on(PULLUP_EN[i])
                );
            end else begin : g_absent
                // Missing pins never driven
                assign PIN_OUT[i] = 1'b0; // RULE1
                assign PIN_OE_N[i] = 1'b1;
                assign PULLUP_EN[i] = 1'b0;
            end
        end
    endgenerate

    // Alternate-function selects and synchronised input levels
    assign EXT_INTERRUPT_THREE_SELECT =
        port_pin_function_select[port1_pkg::BIT_INT_THREE]; // RULE11
    assign EXT_INTERRUPT_TWO_SELECT =
        port_pin_function_select[port1_pkg::BIT_INT_TWO];
    assign EXT_INTERRUPT_ONE_SELECT =
        port_pin_function_select[port1_pkg::BIT_INT_ONE];
    assign TIMER_TRIGGER_INPUT = EXT_INTERRUPT_THREE_SELECT;
    assign EXT_INTERRUPT_THREE_LEVEL = pin_sync[port1_pkg::BIT_INT_THREE];
    assign EXT_INTERRUPT_TWO_LEVEL = pin_sync[port1_pkg::BIT_INT_TWO];
    assign EXT_INTERRUPT_ONE_LEVEL = pin_sync[port1_pkg::BIT_INT_ONE];
    assign TRIGGER_LEVEL = pin_sync[port1_pkg::BIT_INT_THREE];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_dir_write;
        WR && ADDR == port1_pkg::ADDR_DIRECTION;
    endsequence

    sequence s_dir_read;
        RD && ADDR == port1_pkg::ADDR_DIRECTION;
    endsequence

    property p_dir_reads_ones;
        @(posedge SYS_CLK) disable iff (RST)
        s_dir_write ##1 s_dir_read |=> RDATA == 8'hff;
    endproperty
    a_dir_reads_ones: assert property (p_dir_reads_ones) // RULE6
        else $error("Direction read not all ones");

    property p_output_reads_latch;
        @(posedge SYS_CLK) disable iff (RST)
        (RD && ADDR == port1_pkg::ADDR_DATA_LATCH)
        |=> ((RDATA & $past(port_direction_control))
            == ($past(port_data_latch) & $past(port_direction_control)));
    endproperty
    a_output_reads_latch: assert property (p_output_reads_latch) // RULE3
        else $error("Output pin read not latch");

    property p_input_reads_pin;
        @(posedge SYS_CLK) disable iff (RST)
        (RD && ADDR == port1_pkg::ADDR_DATA_LATCH)
        |=> ((RDATA & ~$past(port_direction_control) & 8'hf1)
            == ($past(PIN_IN, 3) & ~$past(port_direction_control) & 8'hf1));
    endproperty
    a_input_reads_pin: assert property (p_input_reads_pin) // RULE4
        else $error("Input pin read not pin level");

    property p_reserved_zero;
        @(posedge SYS_CLK) disable iff (RST)
        (port_data_latch[3:1] == 3'h0) && (port_pullup_enable[3:1] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RULE8
        else $error("Reserved bits not zero");

    property p_fsel_fixed;
        @(posedge SYS_CLK) disable iff (RST)
        (RD && ADDR == port1_pkg::ADDR_FUNC_SEL) |=> RDATA[3:1] == 3'b010;
    endproperty
    a_fsel_fixed: assert property (p_fsel_fixed) // RULE12
        else $error("Function select fixed bits wrong");

    property p_gpio_drive;
        @(posedge SYS_CLK) disable iff (RST)
        (!port_pin_function_select[7] && port_direction_control[7])
        |-> (!PIN_OE_N[7] && PIN_OUT[7] == port_data_latch[7]);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) // RULE13
        else $error("GPIO output not driving latch");

    property p_input_released;
        @(posedge SYS_CLK) disable iff (RST)
        (!port_pin_function_select[6] && !port_direction_control[6])
        |-> (PIN_OE_N[6] && PULLUP_EN[6] == port_pullup_enable[6]);
    endproperty
    a_input_released: assert property (p_input_released) // RULE2
        else $error("Input pin driven or pull-up wrong");

    property p_alt_owns;
        @(posedge SYS_CLK) disable iff (RST)
        port_pin_function_select[4]
        |-> (PIN_OUT[4] == PWM_OUT && !PIN_OE_N[4] && !PULLUP_EN[4]);
    endproperty
    a_alt_owns: assert property (p_alt_owns) // RULE5
        else $error("Alternate function not owning pin");

    property p_write_latch;
        @(posedge SYS_CLK) disable iff (RST)
        (WR && ADDR == port1_pkg::ADDR_DATA_LATCH)
        |=> port_data_latch == ($past(WDATA) & 8'hf1);
    endproperty
    a_write_latch: assert property (p_write_latch) // RULE1
        else $error("Latch write not stored");

endmodule

// ---- dv/port1_board.sv ----
// Board model that drives all eight pin inputs from outside the chip
`timescale 1ns/1ps
module port1_board (
    input wire logic sys_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] wobble = 8'h5a;
    // Floating pins without pull-up never hold a stable level
    always_ff @(posedge sys_clk) begin
        wobble <= ~wobble;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = wobble[i];
            end
        end
    end
endmodule

// ---- dv/port1_gpio_bench.sv ----
// Self-checking bench for the port 1 general-purpose I/O block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module port1_gpio_bench;
    logic sys_clk = 0, rst = 1, wr = 0, rd = 0, pwm = 0, tclk = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, pin_in, pin_out, oe_n, pu_en;
    logic [7:0] ext_en = 8'hff, ext_val = 8'h96;
    logic int3_sel, int2_sel, int1_sel, trig_sel;
    logic int3_lvl, int2_lvl, int1_lvl, trig_lvl;
    logic [7:0] l = 8'h00, d = 8'h00, p = 8'h00, f = 8'h04, q, drv, lv;
    integer seed = 32'h89f4796f;
    int errors = 0, checks_done = 0;
    initial begin
        forever begin
            #2.5 sys_clk = ~sys_clk;
        end
    end
    port1_gpio dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PULLUP_EN(pu_en),
        .PWM_OUT(pwm), .TIMER_CLK_OUT(tclk),
        .EXT_INTERRUPT_THREE_SELECT(int3_sel),
        .EXT_INTERRUPT_TWO_SELECT(int2_sel),
        .EXT_INTERRUPT_ONE_SELECT(int1_sel),
        .TIMER_TRIGGER_INPUT(trig_sel),
        .EXT_INTERRUPT_THREE_LEVEL(int3_lvl),
        .EXT_INTERRUPT_TWO_LEVEL(int2_lvl),
        .EXT_INTERRUPT_ONE_LEVEL(int1_lvl),
        .TRIGGER_LEVEL(trig_lvl));
    port1_board board (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe_n(oe_n), .pullup_en(pu_en), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));
    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= v;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    // ----------------------------------------------------------------
    // Expected pin and register state from the model copy
    // ----------------------------------------------------------------
    task automatic check_all();
        drv = ((~f & d) | (f & 8'h11)) & 8'hf1;
        lv = (drv & ((f & {3'b000, pwm, 3'b000, tclk}) | (~f & l)))
            | (~drv & ext_val);
        idle(4);
        `CHK("pin_oe_n", ~drv, oe_n)
        `CHK("pin_out", lv & drv, pin_out & drv)
        `CHK("pullup_en", p & ~d & ~f & 8'hf1, pu_en)
        `CHK("selects", {f[7], f[6], f[5], f[7]},
            {int3_sel, int2_sel, int1_sel, trig_sel})
        `CHK("levels", {lv[7], lv[6], lv[5], lv[7]},
            {int3_lvl, int2_lvl, int1_lvl, trig_lvl})
        rd_reg(16'hffd4, q);
        `CHK("data", ((d & l) | (~d & lv)) & 8'hf1, q)
        rd_reg(16'hffe4, q);
        `CHK("direction", 8'hff, q)
        rd_reg(16'hffed, q);
        `CHK("pullup", p & 8'hf1, q)
        rd_reg(16'hfffc, q);
        `CHK("func_sel", (f & 8'hf1) | 8'h04, q)
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        check_all();
        $display("test reset done");
        ext_en <= 8'h00;
        wr_reg(16'hffed, 8'hff);
        p = 8'hff;
        idle(4);
        `CHK("pullup_en_on", 8'hf1, pu_en)
        rd_reg(16'hffd4, q);
        `CHK("pulled_pins", 8'hf1, q)
        wr_reg(16'hffe4, 8'hff);
        rd_reg(16'hffe4, q);
        `CHK("dir_after_write", 8'hff, q)
        idle(2);
        `CHK("pullup_en_out", 8'h00, pu_en)
        wr_reg(16'hffed, 8'h00);
        p = 8'h00;
        ext_en <= 8'hff;
        wr_reg(16'hffd4, 8'h0e);
        rd_reg(16'hffd4, q);
        `CHK("back_to_back", 8'h00, q)
        d = 8'hff;
        l = 8'h00;
        rd_reg(16'hffd5, q);
        `CHK("unmapped", 8'h00, q)
        wr_reg(16'hfffd, 8'hff);
        check_all();
        $display("test corners done");
        for (int i = 0; i < 24; i++) begin
            l = 8'($random(seed));
            d = 8'($random(seed));
            p = 8'($random(seed));
            f = (i == 0) ? 8'hff : 8'($random(seed));
            @(posedge sys_clk);
            ext_val <= 8'($random(seed));
            pwm <= 1'($random(seed));
            tclk <= 1'($random(seed));
            wr_reg(16'hffe4, d);
            wr_reg(16'hffd4, l);
            wr_reg(16'hffed, p);
            wr_reg(16'hfffc, f);
            check_all();
        end
        $display("test random done");
        end_sim();
    end
endmodule
